// >>> hdl/switchgear_command_control.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module switchgear_command_control
	import swctl_pkg::*;
#(
	parameter int CYCLES_PER_MS = MS_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        local_permit_in,
	input  wire logic        remote_permit_in,
	input  wire logic        open_interlock_enable,
	input  wire logic        close_interlock_enable,
	input  wire logic        operation_block_in,
	input  wire logic        local_open_req,
	input  wire logic        local_close_req,
	input  wire logic        position_opened_in,
	input  wire logic        position_closed_in,
	output logic             open_pulse_out,
	output logic             close_pulse_out,
	output logic             operation_pulse_out,
	output logic             opened_out,
	output logic             closed_out,
	output logic [1:0]       position_state_code,
	output logic             position_event_out
);
	ctl_state_s  q;
	ctl_state_s  n;
	logic        ms_tick;
	logic [1:0]  pos_code;
	logic        pos_evt;
	logic        loc_open;
	logic        loc_close;
	logic        is_local;
	logic        req;
	logic        conflict;
	logic        want_close;
	logic        is_select;
	logic        permit;
	logic        dir_ok;
	logic        ok;
	logic        go;
	logic        set_ref;
	logic        set_err;
	logic        set_sbo;
	logic        cnt_clr;
	logic        enh;
	logic        success;
	logic        op_timeout;
	logic [1:0]  target;
	logic [CMD_W-1:0] rcmd;
	logic [3:0]  w1c;
	logic [31:0] d;
	logic [31:0] rd;
	logic [31:0] cw;
	logic [31:0] sw;
	logic        pulse_any;

	ms_tick #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_tick (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.ms_tick_out (ms_tick)
	);

	position_filter u_pos (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.ms_tick             (ms_tick),
		.position_opened_in  (position_opened_in),
		.position_closed_in  (position_closed_in),
		.max_int_ms          (q.max_int),
		.position_state_code (pos_code),
		.opened_out          (opened_out),
		.closed_out          (closed_out),
		.position_event_out  (pos_evt)
	);

	always_comb begin
		n       = q;
		rcmd    = '0;
		w1c     = '0;
		cnt_clr = 1'b0;
		d       = '0;
		rd      = '0;
		set_ref = 1'b0;
		set_err = 1'b0;
		set_sbo = 1'b0;
		go      = 1'b0;

		n.sync1    = {local_close_req, local_open_req, operation_block_in, close_interlock_enable,
			open_interlock_enable, remote_permit_in, local_permit_in};
		n.sync2    = q.sync1;
		n.req_prev = {q.sync2.local_close, q.sync2.local_open};

		cw = '0;
		cw[CTRL_MODE_MSB:CTRL_MODE_LSB] = q.model;
		cw[CTRL_FCHK_BIT] = q.forced_chk;
		sw = '0;
		sw[STAT_CODE_MSB:STAT_CODE_LSB] = pos_code;
		sw[STAT_BUSY_BIT] = (q.st == ST_PULSE) || (q.st == ST_SUPV);
		sw[STAT_SEL_BIT] = q.st == ST_SEL;
		sw[STAT_FLG_MSB:STAT_FLG_LSB] = q.flags;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && q.awready) begin
			n.aw_ok   = 1'b1;
			n.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && q.wready) begin
			n.w_ok  = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (n.aw_ok && n.w_ok && !n.bvalid) begin
			n.aw_ok  = 1'b0;
			n.w_ok   = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			case (n.aw_addr)
				REG_CTRL: begin
					d = wmerge(cw, n.wdata, n.wstrb);
					if (d[CTRL_MODE_MSB:CTRL_MODE_LSB] != 2'h3) begin
						n.model = model_e'(d[CTRL_MODE_MSB:CTRL_MODE_LSB]);
					end
					n.forced_chk = d[CTRL_FCHK_BIT];
					cnt_clr = n.wstrb[0] && n.wdata[CTRL_CNTCLR_BIT];
				end
				REG_CMD: begin
					if (n.wstrb[0]) begin
						rcmd = n.wdata[CMD_W-1:0];
					end
				end
				REG_STATUS: begin
					if (n.wstrb[1]) begin
						w1c = n.wdata[STAT_FLG_MSB:STAT_FLG_LSB];
					end
				end
				REG_OPCNT: begin
				end
				REG_MAX_OP: begin
					d = wmerge({16'h0000, q.max_op}, n.wdata, n.wstrb);
					n.max_op = clamp(d[MS_W-1:0], MAX_OP_MIN, MAX_OP_MAX);
				end
				REG_PULSE: begin
					d = wmerge({16'h0000, q.pulse_ms}, n.wdata, n.wstrb);
					n.pulse_ms = clamp(d[MS_W-1:0], PULSE_MIN, PULSE_MAX);
				end
				REG_MAX_INT: begin
					d = wmerge({16'h0000, q.max_int}, n.wdata, n.wstrb);
					n.max_int = clamp(d[MS_W-1:0], MAX_INT_MIN, MAX_INT_MAX);
				end
				REG_SBO: begin
					d = wmerge({16'h0000, q.sbo_ms}, n.wdata, n.wstrb);
					n.sbo_ms = clamp(d[MS_W-1:0], SBO_MIN, SBO_MAX);
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_ok && !n.bvalid;
		n.wready  = !n.w_ok && !n.bvalid;

		// Read channel
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			case (s_axi_araddr[7:0])
				REG_CTRL:    rd = cw;
				REG_CMD:     rd = '0;
				REG_STATUS:  rd = sw;
				REG_OPCNT:   rd = q.op_count;
				REG_MAX_OP:  rd = {16'h0000, q.max_op};
				REG_PULSE:   rd = {16'h0000, q.pulse_ms};
				REG_MAX_INT: rd = {16'h0000, q.max_int};
				REG_SBO:     rd = {16'h0000, q.sbo_ms};
				default: begin
					n.rresp = RESP_SLVERR;
				end
			endcase
			n.rdata = rd;
		end
		n.arready = !n.rvalid;

		// Request qualification
		enh        = q.model != MODEL_DIRECT_NORMAL;
		loc_open   = q.sync2.local_open && !q.req_prev[0];
		loc_close  = q.sync2.local_close && !q.req_prev[1];
		is_local   = loc_open || loc_close;
		req        = is_local || rcmd[CMD_OPEN_BIT] || rcmd[CMD_CLOSE_BIT];
		conflict   = is_local ? (loc_open && loc_close) : (rcmd[CMD_OPEN_BIT] && rcmd[CMD_CLOSE_BIT]);
		want_close = is_local ? loc_close : rcmd[CMD_CLOSE_BIT];
		is_select  = !is_local && rcmd[CMD_SELECT_BIT];
		permit     = is_local ? q.sync2.local_permit : q.sync2.remote_permit;
		dir_ok     = want_close ? q.sync2.close_en : q.sync2.open_en;
		if (!q.forced_chk && !is_local && rcmd[CMD_SKIP_BIT]) begin
			dir_ok = 1'b1;
		end
		ok         = permit && dir_ok && !q.sync2.block && !conflict;
		target     = q.dir_close ? POS_CLOSED : POS_OPENED;
		success    = pos_code == target;
		op_timeout = enh && (q.op_tmr >= q.max_op);

		case (q.st)
			ST_IDLE: begin
				if (req) begin
					if (q.model == MODEL_SBO_ENH && !is_local) begin
						if (is_select && permit && !q.sync2.block && !conflict) begin
							n.st        = ST_SEL;
							n.dir_close = want_close;
							n.tmr       = '0;
						end else begin
							set_ref = 1'b1;
						end
					end else if (ok) begin
						go = 1'b1;
					end else begin
						set_ref = 1'b1;
					end
				end
			end
			ST_SEL: begin
				if (ms_tick) begin
					n.tmr = q.tmr + MS_ONE;
				end
				if (rcmd[CMD_CANCEL_BIT]) begin
					n.st = ST_IDLE;
				end else if (req && !is_local && !is_select && want_close == q.dir_close && ok) begin
					go = 1'b1;
				end else if (req) begin
					set_ref = 1'b1;
					n.st    = ST_IDLE;
				end else if (q.tmr >= q.sbo_ms) begin
					n.st    = ST_IDLE;
					set_sbo = 1'b1;
				end
			end
			ST_PULSE: begin
				set_ref = req;
				if (ms_tick) begin
					n.tmr    = q.tmr + MS_ONE;
					n.op_tmr = q.op_tmr + MS_ONE;
				end
				set_err = op_timeout && !success;
				if (q.tmr >= q.pulse_ms || (success && q.tmr >= PULSE_MIN_MS)) begin
					n.open_pulse  = 1'b0;
					n.close_pulse = 1'b0;
					n.st = (enh && !success && !op_timeout) ? ST_SUPV : ST_IDLE;
				end
			end
			ST_SUPV: begin
				set_ref = req;
				if (ms_tick) begin
					n.op_tmr = q.op_tmr + MS_ONE;
				end
				if (success) begin
					n.st = ST_IDLE;
				end else if (op_timeout) begin
					set_err = 1'b1;
					n.st    = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		if (go) begin
			n.st          = ST_PULSE;
			n.dir_close   = want_close;
			n.tmr         = '0;
			n.op_tmr      = '0;
			n.open_pulse  = !want_close;
			n.close_pulse = want_close;
		end

		// Operation indication and counter
		if (q.oper_pulse && ms_tick) begin
			if (q.oper_ms == OPER_IND_MS - MS_ONE) begin
				n.oper_pulse = 1'b0;
			end else begin
				n.oper_ms = q.oper_ms + MS_ONE;
			end
		end
		if (cnt_clr) begin
			n.op_count = '0;
		end
		if (pos_evt && (pos_code == POS_OPENED || pos_code == POS_CLOSED) && !q.oper_pulse) begin
			n.oper_pulse = 1'b1;
			n.oper_ms    = '0;
			n.op_count   = n.op_count + 32'h0000_0001;
		end

		// Sticky flags: a new event beats a clear in the same cycle
		n.flags = (q.flags & ~w1c) | {pos_evt, set_sbo, set_err, set_ref};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q            <= '0;
			q.model      <= MODEL_DIRECT_NORMAL;
			q.forced_chk <= FCHK_RST;
			q.max_op     <= MAX_OP_DEF;
			q.pulse_ms   <= PULSE_DEF;
			q.max_int    <= MAX_INT_DEF;
			q.sbo_ms     <= SBO_DEF;
		end else begin
			q <= n;
		end
	end

	assign s_axi_awready       = q.awready;
	assign s_axi_wready        = q.wready;
	assign s_axi_bvalid        = q.bvalid;
	assign s_axi_bresp         = q.bresp;
	assign s_axi_arready       = q.arready;
	assign s_axi_rvalid        = q.rvalid;
	assign s_axi_rdata         = q.rdata;
	assign s_axi_rresp         = q.rresp;
	assign open_pulse_out      = q.open_pulse;
	assign close_pulse_out     = q.close_pulse;
	assign operation_pulse_out = q.oper_pulse;
	assign position_state_code = pos_code;
	assign position_event_out  = pos_evt;
	assign pulse_any           = q.open_pulse || q.close_pulse;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_LOCAL_PERMIT: assert property (
		$rose(pulse_any) && $past(is_local) |-> $past(q.sync2.local_permit))
		else $error("local command without local permission");
	AST_REMOTE_PERMIT: assert property (
		$rose(pulse_any) && !$past(is_local) |-> $past(q.sync2.remote_permit))
		else $error("remote command without remote permission");
	AST_OPEN_ILK: assert property (
		$rose(q.open_pulse) && $past(q.forced_chk) |-> $past(q.sync2.open_en))
		else $error("open pulse without open interlock enable");
	AST_CLOSE_ILK: assert property (
		$rose(q.close_pulse) && $past(q.forced_chk) |-> $past(q.sync2.close_en))
		else $error("close pulse without close interlock enable");
	AST_BLOCKED: assert property (
		$rose(pulse_any) |-> !$past(q.sync2.block) && !(q.open_pulse && q.close_pulse))
		else $error("pulse issued while blocked");
	AST_PULSE_LEN: assert property (
		pulse_any && $stable(q.pulse_ms) |-> q.tmr <= q.pulse_ms)
		else $error("command pulse longer than configured");
	AST_MIN_EARLY: assert property (
		$fell(pulse_any) |-> $past(q.tmr) >= $past(q.pulse_ms) || $past(q.tmr) >= PULSE_MIN_MS)
		else $error("command pulse withdrawn before minimum");
	AST_SBO_TIMEOUT: assert property (
		q.st == ST_SEL && $stable(q.sbo_ms) |-> q.tmr <= q.sbo_ms)
		else $error("selection outlived its timeout");
	AST_OP_ERR: assert property (
		q.st == ST_SUPV && op_timeout && !success |=> q.flags[FLG_ERR] && q.st == ST_IDLE)
		else $error("operating time expiry not reported");
	AST_BUSY_REFUSE: assert property (
		$rose(pulse_any) |-> $past(q.st) == ST_IDLE || $past(q.st) == ST_SEL)
		else $error("new command started while busy");
	AST_OPER_LEN: assert property (
		$fell(q.oper_pulse) |-> $past(q.oper_ms) == OPER_IND_MS - MS_ONE && $past(ms_tick))
		else $error("operation indication has wrong length");
	AST_OPCNT: assert property (
		$rose(q.oper_pulse) && !$past(cnt_clr) |-> q.op_count == $past(q.op_count) + 32'h1)
		else $error("operation counter missed an operation");

	COV_OPEN_PULSE: cover property ($rose(q.open_pulse));
	COV_SBO_EXPIRE: cover property (set_sbo);
	COV_EARLY_END: cover property ($fell(pulse_any) && $past(q.tmr) < $past(q.pulse_ms));
	COV_REFUSED: cover property (set_ref && q.st == ST_PULSE);
endmodule

// >>> pkg/swctl_pkg.sv
package swctl_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W        = 20;
	localparam int MS_W          = 16;

	typedef logic [MS_W-1:0] ms_t;

	localparam ms_t MS_ONE       = 16'h0001;
	localparam ms_t MAX_OP_MIN   = 16'h000A;
	localparam ms_t MAX_OP_MAX   = 16'hEA60;
	localparam ms_t MAX_OP_DEF   = 16'h2710;
	localparam ms_t PULSE_MIN    = 16'h0064;
	localparam ms_t PULSE_MAX    = 16'hEA60;
	localparam ms_t PULSE_DEF    = 16'h03E8;
	localparam ms_t PULSE_MIN_MS = 16'h03E8;
	localparam ms_t MAX_INT_MIN  = 16'h0014;
	localparam ms_t MAX_INT_MAX  = 16'hEA60;
	localparam ms_t MAX_INT_DEF  = 16'h2710;
	localparam ms_t SBO_MIN      = 16'h03E8;
	localparam ms_t SBO_MAX      = 16'h4E20;
	localparam ms_t SBO_DEF      = 16'h1388;
	localparam ms_t OPER_IND_MS  = 16'h0096;

	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_OPCNT   = 8'h0C;
	localparam logic [7:0] REG_MAX_OP  = 8'h10;
	localparam logic [7:0] REG_PULSE   = 8'h14;
	localparam logic [7:0] REG_MAX_INT = 8'h18;
	localparam logic [7:0] REG_SBO     = 8'h1C;

	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_MODE_MSB   = 1;
	localparam int CTRL_FCHK_BIT   = 2;
	localparam int CTRL_CNTCLR_BIT = 3;
	localparam int CMD_OPEN_BIT    = 0;
	localparam int CMD_CLOSE_BIT   = 1;
	localparam int CMD_SELECT_BIT  = 2;
	localparam int CMD_CANCEL_BIT  = 3;
	localparam int CMD_SKIP_BIT    = 4;
	localparam int CMD_W           = 5;
	localparam int STAT_CODE_LSB   = 0;
	localparam int STAT_CODE_MSB   = 1;
	localparam int STAT_BUSY_BIT   = 4;
	localparam int STAT_SEL_BIT    = 5;
	localparam int STAT_FLG_LSB    = 8;
	localparam int STAT_FLG_MSB    = 11;
	localparam int FLG_REF         = 0;
	localparam int FLG_ERR         = 1;
	localparam int FLG_SBO         = 2;
	localparam int FLG_EVT         = 3;

	localparam logic       FCHK_RST    = 1'b1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [1:0] POS_INTERMEDIATE = 2'h0;
	localparam logic [1:0] POS_OPENED       = 2'h1;
	localparam logic [1:0] POS_CLOSED       = 2'h2;
	localparam logic [1:0] POS_BAD          = 2'h3;

	typedef enum logic [1:0] {
		MODEL_DIRECT_NORMAL = 2'b00,
		MODEL_DIRECT_ENH    = 2'b01,
		MODEL_SBO_ENH       = 2'b10
	} model_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SEL   = 2'b01,
		ST_PULSE = 2'b10,
		ST_SUPV  = 2'b11
	} ctl_state_e;

	typedef struct packed {
		logic local_close;
		logic local_open;
		logic block;
		logic close_en;
		logic open_en;
		logic remote_permit;
		logic local_permit;
	} pins_s;

	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic              tick;
	} tick_state_s;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] code;
		ms_t        int_ms;
		logic       evt;
	} pos_state_s;

	typedef struct packed {
		pins_s       sync1;
		pins_s       sync2;
		logic [1:0]  req_prev;
		model_e      model;
		logic        forced_chk;
		ms_t         max_op;
		ms_t         pulse_ms;
		ms_t         max_int;
		ms_t         sbo_ms;
		ctl_state_e  st;
		logic        dir_close;
		ms_t         tmr;
		ms_t         op_tmr;
		logic        open_pulse;
		logic        close_pulse;
		logic        oper_pulse;
		ms_t         oper_ms;
		logic [31:0] op_count;
		logic [3:0]  flags;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        aw_ok;
		logic [7:0]  aw_addr;
		logic        w_ok;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} ctl_state_s;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic ms_t clamp(input ms_t v, input ms_t lo, input ms_t hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

endpackage

// >>> hdl/ms_tick.sv
`timescale 1ns/1ps
module ms_tick
	import swctl_pkg::*;
#(
	parameter int CYCLES_PER_MS = MS_CYCLES
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      ms_tick_out
);
	tick_state_s q;
	tick_state_s n;

	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (q.cnt == TICK_W'(CYCLES_PER_MS - 1)) begin
			n.cnt  = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + {{(TICK_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign ms_tick_out = q.tick;
endmodule

// >>> hdl/position_filter.sv
`timescale 1ns/1ps
module position_filter
	import swctl_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ms_tick,
	input  wire logic       position_opened_in,
	input  wire logic       position_closed_in,
	input  wire ms_t        max_int_ms,
	output logic [1:0]      position_state_code,
	output logic            opened_out,
	output logic            closed_out,
	output logic            position_event_out
);
	pos_state_s q;
	pos_state_s n;
	logic       opened_reg;
	logic       closed_reg;

	always_comb begin
		n = q;
		n.s1 = {position_closed_in, position_opened_in};
		n.s2 = q.s1;
		if (q.s2 != POS_INTERMEDIATE) begin
			n.code   = q.s2;
			n.int_ms = '0;
		end else begin
			if (ms_tick && q.int_ms < max_int_ms) begin
				n.int_ms = q.int_ms + MS_ONE;
			end
			if (q.int_ms >= max_int_ms) begin
				n.code = POS_INTERMEDIATE;
			end
		end
		n.evt = n.code != q.code;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q          <= '0;
			opened_reg <= 1'b0;
			closed_reg <= 1'b0;
		end else begin
			q          <= n;
			opened_reg <= n.code == POS_OPENED;
			closed_reg <= n.code == POS_CLOSED;
		end
	end

	assign position_state_code = q.code;
	assign position_event_out  = q.evt;
	assign opened_out          = opened_reg;
	assign closed_out          = closed_reg;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_POS_ENCODE: assert property (
		q.s2 != POS_INTERMEDIATE |=> position_state_code == $past(q.s2))
		else $error("position code does not follow inputs");
	AST_POS_FILTERED: assert property (
		(opened_out == (position_state_code == POS_OPENED)) &&
		(closed_out == (position_state_code == POS_CLOSED)))
		else $error("filtered outputs disagree with position code");
	AST_POS_EVENT: assert property (
		position_event_out == (position_state_code != $past(position_state_code)))
		else $error("position event does not match a code change");
	AST_POS_INT_HOLD: assert property (
		$fell(position_state_code != POS_INTERMEDIATE) && $past(q.s2) == POS_INTERMEDIATE
		|-> $past(q.int_ms) >= $past(max_int_ms))
		else $error("intermediate reported before the wait expired");
endmodule

// >>> bench/contact_model.sv
`timescale 1ns/1ps
module contact_model #(
	parameter int DLY = 40
) (
	input  wire logic aclk,
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	output logic      opened,
	output logic      closed
);
	int   cnt = 0;
	logic pos_closed = 1'h1;
	logic moving;
	// Both contacts off while the blades travel
	assign moving = (open_cmd || close_cmd) && cnt <= DLY;
	assign opened = !moving && !pos_closed;
	assign closed = !moving && pos_closed;
	always @(posedge aclk) begin
		cnt <= (open_cmd || close_cmd) ? cnt + 1 : 0;
		if (cnt == DLY)
			pos_closed <= close_cmd;
	end
endmodule

// >>> bench/switchgear_command_control_tb_top.sv
`timescale 1ns/1ps
module switchgear_command_control_tb_top;
	import swctl_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic local_permit_in = 1'h1, remote_permit_in = 1'h1, open_interlock_enable = 1'h1;
	logic close_interlock_enable = 1'h1, operation_block_in = 1'h0;
	logic local_open_req = 1'h0, local_close_req = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, position_state_code, rsp;
	logic open_pulse_out, close_pulse_out, operation_pulse_out, opened_out, closed_out;
	logic position_event_out, position_opened_in, position_closed_in;
	int error_cnt = 0, n_tests = 0, n;

	always #4 aclk = ~aclk;

	switchgear_command_control #(.CYCLES_PER_MS(10)) dut (.aclk, .aresetn, .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .local_permit_in,
		.remote_permit_in, .open_interlock_enable, .close_interlock_enable, .operation_block_in,
		.local_open_req, .local_close_req, .position_opened_in, .position_closed_in,
		.open_pulse_out, .close_pulse_out, .operation_pulse_out, .opened_out, .closed_out,
		.position_state_code, .position_event_out);

	contact_model pm (.aclk, .open_cmd(open_pulse_out), .close_cmd(close_pulse_out),
		.opened(position_opened_in), .closed(position_closed_in));

	task close_out;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// Command that must be refused; p is the pulse pair seen meanwhile
	task rf(input logic [31:0] c, input logic [1:0] p);
		repeat (4) @(posedge aclk);
		wr(REG_CMD, c);
		chk("pulses", p, {open_pulse_out, close_pulse_out});
		rd(REG_STATUS);
		chk("refused", 1'h1, rdat[STAT_FLG_LSB+FLG_REF]);
		wr(REG_STATUS, 32'h00000F00);
	endtask

	task plen(input logic cl, input logic [1:0] pos);
		n = 0;
		while ((cl ? close_pulse_out : open_pulse_out) === 1'h1 && n < 30000) begin
			@(posedge aclk);
			n++;
			if (n == 300) chk("oper", 1'h1, operation_pulse_out);
			if (position_event_out === 1'h1) chk("event", pos, position_state_code);
		end
		chk("len", 1'h1, n >= 9950 && n <= 10012);
		chk("code", pos, position_state_code);
		chk("filt", {pos == POS_CLOSED, pos == POS_OPENED}, {closed_out, opened_out});
	endtask

	initial begin
		repeat (50000) @(posedge aclk);
		error_cnt++;
		close_out;
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("code", POS_CLOSED, position_state_code);
		rd(REG_CTRL);
		chk("ctrl", 32'h00000004, rdat);
		rd(REG_PULSE);
		chk("pulse", 32'h000003E8, rdat);
		rd(8'h40);
		chk("resp", RESP_SLVERR, rsp);
		wr(8'h40, 32'h00000000);
		chk("bresp", RESP_SLVERR, rsp);
		wr(REG_PULSE, 32'h00000010);
		rd(REG_PULSE);
		chk("clamp", 32'h00000064, rdat);
		wr(REG_PULSE, 32'h000007D0);
		remote_permit_in <= 1'h0;
		rf(32'h00000002, 2'h0);
		remote_permit_in <= 1'h1;
		operation_block_in <= 1'h1;
		rf(32'h00000001, 2'h0);
		operation_block_in <= 1'h0;
		close_interlock_enable <= 1'h0;
		rf(32'h00000002, 2'h0);
		rf(32'h00000012, 2'h0);
		close_interlock_enable <= 1'h1;
		wr(REG_CMD, 32'h00000001);
		chk("open", 1'h1, open_pulse_out);
		rf(32'h00000002, 2'h2);
		plen(1'h0, POS_OPENED);
		rd(REG_OPCNT);
		chk("count", 32'h00000001, rdat);
		local_close_req <= 1'h1;
		repeat (6) @(posedge aclk);
		chk("close", 1'h1, close_pulse_out);
		plen(1'h1, POS_CLOSED);
		wr(REG_CTRL, 32'h0000000C);
		rd(REG_OPCNT);
		chk("cleared", 32'h00000000, rdat);
		wr(REG_CTRL, 32'h00000006);
		wr(REG_SBO, 32'h00000000);
		wr(REG_CMD, 32'h00000005);
		rd(REG_STATUS);
		chk("sel", 1'h1, rdat[STAT_SEL_BIT]);
		repeat (10050) @(posedge aclk);
		rd(REG_STATUS);
		chk("sbo", 2'h2, {rdat[STAT_FLG_LSB+FLG_SBO], rdat[STAT_SEL_BIT]});
		chk("nopulse", 2'h0, {open_pulse_out, close_pulse_out});
		close_out;
	end
endmodule
